// ---- sps_top.sv ----
// module: serial port (spi / i2c slave) with status flags and apb registers
//
// Overview of operation
// - edge select picks transmit clock transition
// - idle/active clock levels come from polarity
// - data/address flag tracks last received byte
// - stop flag set when stop seen last
// - start flag set when start seen last
// - store read/write bit until start, stop, ack
// - buffer full set when received byte waits
// - buffer full held during i2c transmit
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
module sps_top
(
   input wire logic pclk, // system clock, 250 MHz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction, high = write
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic link_clk_i, // serial clock pin (sck / scl)
   input wire logic link_dat_i, // serial data in (sdi / sda)
   output logic sdo_o, // spi data out
   output logic sda_o, // i2c data out level, always low
   output logic sda_oe, // i2c data pull-down enable
   output logic irq // interrupt, level
);
   // -------------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------------
   sps_pin_if pin_bus ();
   sps_pkg::sps_state_t state_reg;
   logic [7:0] ctrl_reg;
   logic [7:0] own_addr_reg;
   logic [7:0] serial_buffer;
   logic [7:0] shift_reg;
   logic [7:0] tx_reg;
   logic [3:0] bit_cnt_reg;
   logic smp_reg;
   logic cke_reg;
   logic da_reg;
   logic stop_reg;
   logic start_reg;
   logic rw_reg;
   logic buffer_full_flag;
   logic dir_read_reg;
   logic sdo_reg;
   logic sda_oe_reg;
   logic [sps_pkg::IRQ_W-1:0] irq_stat_reg;
   logic [sps_pkg::IRQ_W-1:0] irq_en_reg;
   logic irq_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic spi_mode;
   logic i2c_mode;
   logic tx_edge;
   logic sample_edge;
   logic spi_done;
   logic i2c_last;
   logic addr_hit;
   logic data_rx;
   logic tx_done;
   logic ack_clear;
   logic start_ev;
   logic stop_ev;
   logic [7:0] full_byte;
   logic [7:0] serial_status_reg;
   logic wr_en;
   logic rd_en;
   logic [sps_pkg::IRQ_W-1:0] irq_ev;

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = (addr == off);
   endfunction

   function automatic logic mapped(input logic [7:0] addr);
      mapped = hit(addr, sps_pkg::ADDR_STATUS) | hit(addr, sps_pkg::ADDR_CONTROL)
             | hit(addr, sps_pkg::ADDR_BUFFER) | hit(addr, sps_pkg::ADDR_OWN)
             | hit(addr, sps_pkg::ADDR_IRQ_STAT) | hit(addr, sps_pkg::ADDR_IRQ_EN)
             | hit(addr, sps_pkg::ADDR_IRQ_CLR);
   endfunction

   sps_pin_sync u_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .clk_pin(link_clk_i),
      .dat_pin(link_dat_i),
      .pins(pin_bus.src)
   );

   // -------------------------------------------------------------------
   // decode of mode, edges and byte events
   // -------------------------------------------------------------------
   assign spi_mode = ctrl_reg[sps_pkg::CT_EN] & ~ctrl_reg[sps_pkg::CT_I2C];
   assign i2c_mode = ctrl_reg[sps_pkg::CT_EN] & ctrl_reg[sps_pkg::CT_I2C];
   // active->idle is a fall for idle-low clocks, a rise for idle-high
   assign tx_edge = (cke_reg ^ ctrl_reg[sps_pkg::CT_CKP]) ? pin_bus.clk_fall
                  : pin_bus.clk_rise;
   assign sample_edge = (cke_reg ^ ctrl_reg[sps_pkg::CT_CKP]) ? pin_bus.clk_rise
                      : pin_bus.clk_fall;
   assign full_byte = {shift_reg[6:0], pin_bus.dat_lvl};
   assign spi_done = spi_mode & sample_edge & (bit_cnt_reg == sps_pkg::LAST_BIT);
   assign i2c_last = i2c_mode & pin_bus.clk_rise & (bit_cnt_reg == sps_pkg::LAST_BIT);
   assign addr_hit = i2c_last & (state_reg == sps_pkg::SPS_ADDR)
                   & (full_byte[7:1] == own_addr_reg[6:0]);
   assign data_rx = i2c_last & (state_reg == sps_pkg::SPS_RXD);
   assign tx_done = i2c_last & (state_reg == sps_pkg::SPS_TXD);
   assign start_ev = i2c_mode & pin_bus.start_det;
   assign stop_ev = i2c_mode & pin_bus.stop_det;
   // end of our ack after a data byte, or the master's ack in a read
   assign ack_clear = (state_reg == sps_pkg::SPS_ACK) & pin_bus.clk_fall & sda_oe_reg & da_reg
                    | (state_reg == sps_pkg::SPS_TXD) & dir_read_reg & pin_bus.clk_rise
                      & bit_cnt_reg[3];

   // -------------------------------------------------------------------
   // apb slave: zero-wait access, pready high in every access phase
   // -------------------------------------------------------------------
   assign wr_en = psel & penable & pready_reg & pwrite;
   assign rd_en = psel & penable & pready_reg & ~pwrite;

   always_comb
   begin
      serial_status_reg = 8'h00;
      serial_status_reg[sps_pkg::ST_SMP] = smp_reg;
      serial_status_reg[sps_pkg::ST_CKE] = cke_reg;
      serial_status_reg[sps_pkg::ST_DA] = da_reg;
      serial_status_reg[sps_pkg::ST_STOP] = stop_reg;
      serial_status_reg[sps_pkg::ST_START] = start_reg;
      serial_status_reg[sps_pkg::ST_RW] = rw_reg;
      serial_status_reg[sps_pkg::ST_UA] = 1'b0;
      serial_status_reg[sps_pkg::ST_BF] = buffer_full_flag;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end
      else
      begin
         pready_reg <= psel & ~penable;
         pslverr_reg <= psel & ~penable & ~mapped(paddr);
         if (psel & ~penable & ~pwrite)
         begin
            case (1'b1)
               hit(paddr, sps_pkg::ADDR_STATUS): prdata_reg <= {24'h00_0000, serial_status_reg};
               hit(paddr, sps_pkg::ADDR_CONTROL): prdata_reg <= {24'h00_0000, ctrl_reg};
               hit(paddr, sps_pkg::ADDR_BUFFER): prdata_reg <= {24'h00_0000, serial_buffer};
               hit(paddr, sps_pkg::ADDR_OWN): prdata_reg <= {24'h00_0000, own_addr_reg};
               hit(paddr, sps_pkg::ADDR_IRQ_STAT): prdata_reg <= {29'h0000_0000, irq_stat_reg};
               hit(paddr, sps_pkg::ADDR_IRQ_EN): prdata_reg <= {29'h0000_0000, irq_en_reg};
               default: prdata_reg <= 32'h0000_0000;
            endcase
         end
      end
   end

   // -------------------------------------------------------------------
   // software-writable configuration
   // -------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= sps_pkg::CTRL_RESET;
         own_addr_reg <= sps_pkg::OWN_RESET;
         smp_reg <= 1'b0;
         cke_reg <= 1'b0;
         irq_en_reg <= '0;
      end
      else if (wr_en)
      begin
         if (hit(paddr, sps_pkg::ADDR_CONTROL))
            ctrl_reg <= pwdata[7:0];
         if (hit(paddr, sps_pkg::ADDR_OWN))
            own_addr_reg <= pwdata[7:0];
         if (hit(paddr, sps_pkg::ADDR_IRQ_EN))
            irq_en_reg <= pwdata[sps_pkg::IRQ_W-1:0];
         // only the two configuration bits of the status word take a write
         if (hit(paddr, sps_pkg::ADDR_STATUS))
         begin
            smp_reg <= pwdata[sps_pkg::ST_SMP];
            cke_reg <= pwdata[sps_pkg::ST_CKE];
         end
      end
   end

   // -------------------------------------------------------------------
   // transmit byte and spi data out
   // -------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_reg <= 8'h00;
         sdo_reg <= 1'b0;
      end
      else if (wr_en && hit(paddr, sps_pkg::ADDR_BUFFER))
      begin
         tx_reg <= pwdata[7:0];
         sdo_reg <= pwdata[7];
      end
      else if (spi_mode && tx_edge && (cke_reg || bit_cnt_reg != 4'h0))
      begin
         // msb already on the pin; a leading-edge first transmit must keep it there
         tx_reg <= {tx_reg[6:0], 1'b0};
         sdo_reg <= tx_reg[6];
      end
   end

   // -------------------------------------------------------------------
   // shift engine: spi slave and i2c slave
   // -------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= sps_pkg::SPS_IDLE;
         shift_reg <= 8'h00;
         bit_cnt_reg <= 4'h0;
         dir_read_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
      end
      else if (spi_mode)
      begin
         state_reg <= sps_pkg::SPS_IDLE;
         sda_oe_reg <= 1'b0;
         if (sample_edge)
         begin
            shift_reg <= full_byte;
            bit_cnt_reg <= spi_done ? 4'h0 : bit_cnt_reg + 4'h1;
         end
      end
      else if (!i2c_mode || stop_ev)
      begin
         state_reg <= sps_pkg::SPS_IDLE;
         bit_cnt_reg <= 4'h0;
         sda_oe_reg <= 1'b0;
      end
      else if (start_ev)
      begin
         state_reg <= sps_pkg::SPS_ADDR;
         bit_cnt_reg <= 4'h0;
         sda_oe_reg <= 1'b0;
      end
      else
      begin
         case (state_reg)
            sps_pkg::SPS_IDLE:
               bit_cnt_reg <= 4'h0;
            sps_pkg::SPS_ADDR, sps_pkg::SPS_RXD:
            begin
               if (pin_bus.clk_rise)
               begin
                  shift_reg <= full_byte;
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  if (i2c_last)
                  begin
                     if (state_reg == sps_pkg::SPS_RXD || addr_hit)
                        state_reg <= sps_pkg::SPS_ACK;
                     else
                        state_reg <= sps_pkg::SPS_IDLE;
                     if (addr_hit)
                        dir_read_reg <= full_byte[0];
                  end
               end
            end
            sps_pkg::SPS_ACK:
            begin
               // first fall pulls data low, second fall releases it in a write or drives the first data bit in a read
               if (pin_bus.clk_fall)
               begin
                  bit_cnt_reg <= 4'h0;
                  if (!sda_oe_reg)
                     sda_oe_reg <= 1'b1;
                  else if (dir_read_reg)
                  begin
                     state_reg <= sps_pkg::SPS_TXD;
                     sda_oe_reg <= ~tx_reg[7];
                  end
                  else
                  begin
                     state_reg <= sps_pkg::SPS_RXD;
                     sda_oe_reg <= 1'b0;
                  end
               end
            end
            sps_pkg::SPS_TXD:
            begin
               // counts 0..7 are data bits, count 8 is the master's ack slot
               if (pin_bus.clk_fall)
                  sda_oe_reg <= bit_cnt_reg[3] ? 1'b0 : ~tx_reg[3'h7 - bit_cnt_reg[2:0]];
               if (pin_bus.clk_rise)
               begin
                  if (!bit_cnt_reg[3])
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  else if (!pin_bus.dat_lvl)
                     bit_cnt_reg <= 4'h0;
                  else
                     state_reg <= sps_pkg::SPS_IDLE;
               end
            end
            default:
               state_reg <= sps_pkg::SPS_IDLE;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // bus condition and byte-type flags
   // -------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         start_reg <= 1'b0;
         stop_reg <= 1'b0;
      end
      else if (start_ev)
      begin
         start_reg <= 1'b1;
         stop_reg <= 1'b0;
      end
      else if (stop_ev)
      begin
         start_reg <= 1'b0;
         stop_reg <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         da_reg <= 1'b0;
      else if (addr_hit)
         da_reg <= 1'b0;
      else if (data_rx)
         da_reg <= 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rw_reg <= 1'b0;
      else if (addr_hit)
         rw_reg <= full_byte[0];
      else if (start_ev || stop_ev || ack_clear)
         rw_reg <= 1'b0;
   end

   // -------------------------------------------------------------------
   // receive buffer and buffer-full flag; a set beats a same-cycle clear
   // -------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         serial_buffer <= 8'h00;
      else if (spi_done || addr_hit || data_rx)
         serial_buffer <= full_byte;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         buffer_full_flag <= 1'b0;
      else if (spi_done || addr_hit || data_rx)
         buffer_full_flag <= 1'b1;
      else if (i2c_mode && wr_en && hit(paddr, sps_pkg::ADDR_BUFFER))
         buffer_full_flag <= 1'b1;
      else if (tx_done)
         buffer_full_flag <= 1'b0;
      else if (rd_en && hit(paddr, sps_pkg::ADDR_BUFFER))
         buffer_full_flag <= 1'b0;
   end

   // -------------------------------------------------------------------
   // interrupts: sticky status, enable, write-one-to-clear
   // -------------------------------------------------------------------
   assign irq_ev = {stop_ev, start_ev, spi_done | addr_hit | data_rx | tx_done};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_stat_reg <= '0;
         irq_reg <= 1'b0;
      end
      else
      begin
         if (wr_en && hit(paddr, sps_pkg::ADDR_IRQ_CLR))
            irq_stat_reg <= (irq_stat_reg & ~pwdata[sps_pkg::IRQ_W-1:0]) | irq_ev;
         else
            irq_stat_reg <= irq_stat_reg | irq_ev;
         irq_reg <= |(irq_stat_reg & irq_en_reg);
      end
   end

   // -------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign sdo_o = sdo_reg;
   // open-drain: the level is always low, only the enable moves
   assign sda_o = 1'b0;
   assign sda_oe = sda_oe_reg;
   assign irq = irq_reg;
endmodule

// ---- sps_pkg.sv ----
// package: register map, field positions and reset values of the serial port status block
package sps_pkg;
   // -------------------------------------------------------------------
   // register byte offsets
   // -------------------------------------------------------------------
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CONTROL = 8'h04;
   localparam logic [7:0] ADDR_BUFFER = 8'h08;
   localparam logic [7:0] ADDR_OWN = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
   // -------------------------------------------------------------------
   // status register fields
   // -------------------------------------------------------------------
   localparam int ST_SMP = 7;
   localparam int ST_CKE = 6;
   localparam int ST_DA = 5;
   localparam int ST_STOP = 4;
   localparam int ST_START = 3;
   localparam int ST_RW = 2;
   localparam int ST_UA = 1;
   localparam int ST_BF = 0;
   // -------------------------------------------------------------------
   // control register fields
   // -------------------------------------------------------------------
   localparam int CT_EN = 5;
   localparam int CT_CKP = 4;
   localparam int CT_I2C = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] OWN_RESET = 8'h00;
   // -------------------------------------------------------------------
   // interrupt fields
   // -------------------------------------------------------------------
   localparam int IRQ_W = 3;
   localparam int IRQ_BYTE = 0;
   localparam int IRQ_START = 1;
   localparam int IRQ_STOP = 2;
   localparam logic [3:0] LAST_BIT = 4'h7;
   typedef enum logic [4:0] {
      SPS_IDLE = 5'b0_0001,
      SPS_ADDR = 5'b0_0010,
      SPS_RXD = 5'b0_0100,
      SPS_TXD = 5'b0_1000,
      SPS_ACK = 5'b1_0000
   } sps_state_t;
endpackage

// ---- sps_pin_if.sv ----
// interface: synchronised link pin levels and detected events
`timescale 1ns/1ps
interface sps_pin_if;
   logic clk_lvl;
   logic dat_lvl;
   logic clk_rise;
   logic clk_fall;
   logic start_det;
   logic stop_det;
   modport src (output clk_lvl, dat_lvl, clk_rise, clk_fall, start_det, stop_det);
   modport dst (input clk_lvl, dat_lvl, clk_rise, clk_fall, start_det, stop_det);
endinterface

// ---- sps_pin_sync.sv ----
// module: two-stage synchronisers and edge/condition detection for the link pins
`timescale 1ns/1ps
module sps_pin_sync
(
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic clk_pin, // serial clock pin
   input wire logic dat_pin, // serial data pin
   sps_pin_if.src pins // synchronised levels and events
);
   logic [1:0] meta_reg;
   logic [1:0] sync_reg;
   logic [1:0] prev_reg;

   // -------------------------------------------------------------------
   // synchroniser; meta_reg feeds only sync_reg
   // -------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_reg <= 2'h0;
         sync_reg <= 2'h0;
         prev_reg <= 2'h0;
      end
      else
      begin
         meta_reg <= {clk_pin, dat_pin};
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign pins.clk_lvl = sync_reg[1];
   assign pins.dat_lvl = sync_reg[0];
   assign pins.clk_rise = sync_reg[1] & ~prev_reg[1];
   assign pins.clk_fall = ~sync_reg[1] & prev_reg[1];
   // data moving while the clock stays high marks a bus condition
   assign pins.start_det = sync_reg[1] & prev_reg[1] & ~sync_reg[0] & prev_reg[0];
   assign pins.stop_det = sync_reg[1] & prev_reg[1] & sync_reg[0] & ~prev_reg[0];
endmodule

// ---- sps_sva.sv ----
// checker: bus and pin relations of the serial port status block
`timescale 1ns/1ps
module sps_sva
(
   input wire logic pclk, // clock
   input wire logic presetn, // reset, active low
   input wire logic psel, // select
   input wire logic penable, // enable
   input wire logic pwrite, // direction
   input wire logic [7:0] paddr, // address
   input wire logic [31:0] pwdata, // write data
   input wire logic [31:0] prdata, // read data
   input wire logic pready, // ready
   input wire logic pslverr, // error
   input wire logic link_clk_i, // link clock
   input wire logic link_dat_i, // link data
   input wire logic sdo_o, // spi out
   input wire logic sda_o, // sda level
   input wire logic sda_oe, // sda pull enable
   input wire logic irq // interrupt
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // -------------------------------------------------------------------
   // bus answers
   // -------------------------------------------------------------------
   ready_follows_a: assert property (psel && !penable |=> pready) else $error("ready missing");
   ready_only_a: assert property (pready |-> $past(psel) && psel && penable)
      else $error("stray ready");
   unmapped_err_a: assert property (pready && paddr > 8'h18
      |-> pslverr && (pwrite || prdata == 32'h0000_0000))
      else $error("unmapped access not refused");
   mapped_ok_a: assert property (pready && paddr <= 8'h18 && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("mapped access refused");
   upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
      else $error("upper read bits set");
   clear_reads_a: assert property (pready && !pwrite && paddr == sps_pkg::ADDR_IRQ_CLR
      |-> prdata == 32'h0000_0000) else $error("clear register reads nonzero");
   // -------------------------------------------------------------------
   // status flags, pins and interrupt
   // -------------------------------------------------------------------
   spare_bit_a: assert property (pready && !pwrite && paddr == sps_pkg::ADDR_STATUS
      |-> !prdata[sps_pkg::ST_UA]) else $error("spare status bit set");
   start_stop_a: assert property (pready && !pwrite && paddr == sps_pkg::ADDR_STATUS
      |-> !(prdata[sps_pkg::ST_START] && prdata[sps_pkg::ST_STOP])) else $error("start and stop both set");
   sda_level_a: assert property (sda_o == 1'b0) else $error("sda level driven high");
   irq_mask_a: assert property (pready && pwrite && paddr == sps_pkg::ADDR_IRQ_EN
      && pwdata[2:0] == 3'b000 |-> ##2 !irq) else $error("masked interrupt raised");
endmodule
bind sps_top sps_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .link_clk_i(link_clk_i), .link_dat_i(link_dat_i), .sdo_o(sdo_o),
   .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));

// ---- sps_link_model.sv ----
// model: serial link master that drives clock and data and reads the slave back
`timescale 1ns/1ps
module sps_link_model
(
   output logic link_clk, // serial clock to the slave
   output logic link_dat, // data line as the slave sees it
   input wire logic sdo, // spi data from the slave
   input wire logic sda_oe // slave pull-down on sda
);
   logic drv = 1'b1;
   logic ck = 1'b1;
   // pins move 1 ns after the model's steps, off the system clock edges
   assign #1 link_clk = ck;
   // open drain with pull-up: the slave can only pull low
   assign #1 link_dat = drv & ~sda_oe;
   task automatic idle(input logic lvl);
      ck = lvl;
      drv = 1'b1;
   endtask
   // sdo taken late in the active phase, clear of the sync delay
   task automatic spi_xfer(input logic clock_polarity, input logic [7:0] mo, output logic [7:0] mi);
      for (int i = 7; i >= 0; i--)
      begin
         drv = mo[i];
         #8 ck = ~clock_polarity;
         #14 mi[i] = sdo;
         #2 ck = clock_polarity;
         #8;
      end
      drv = ~mo[0];
   endtask
   task automatic i2c_cond(input logic stop);
      if (stop)
      begin
         ck = 1'b0;
         #8 drv = 1'b0;
         #8 ck = 1'b1;
      end
      #8 drv = stop;
      #16;
   endtask
   // clock is left high after each bit so software can act mid-frame
   task automatic i2c_bit(input logic b, output logic s);
      ck = 1'b0;
      #8 drv = b;
      #8 ck = 1'b1;
      #14 s = link_dat;
      #2;
   endtask
   task automatic i2c_byte(input logic [7:0] mo, input logic mack, output logic [7:0] mi,
      output logic sack);
      logic a;
      for (int i = 7; i >= 0; i--)
         i2c_bit(mo[i], mi[i]);
      i2c_bit(mack, a);
      sack = ~a;
   endtask
endmodule

// ---- tb_top.sv ----
// testbench: apb register checks and spi / i2c slave traffic against the link model
`timescale 1ns/1ps
module tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata, rd;
   logic pready, pslverr, lclk, ldat, sdo, sda_o, sda_oe, irq, se, ack;
   logic [7:0] got, rx, tx, own;
   int err_count = 0;
   int tests_run = 0;
   int cyc = 0;
   sps_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link_clk_i(lclk), .link_dat_i(ldat), .sdo_o(sdo), .sda_o(sda_o),
      .sda_oe(sda_oe), .irq(irq));
   sps_link_model link (.link_clk(lclk), .link_dat(ldat), .sdo(sdo), .sda_oe(sda_oe));
   initial forever #2 pclk = ~pclk;
   task automatic end_sim;
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      check(rd & m, e);
   endtask
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         err_count++;
         end_sim;
      end
   end
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} <= 43'h000_0000_0000;
      void'($urandom(85));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rdc(sps_pkg::ADDR_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
      rdc(sps_pkg::ADDR_CONTROL, 32'hFFFF_FFFF, 32'h0000_0000);
      apb(1'b1, 8'h1C, 32'h0000_00FF);
      check(32'(se), 32'h0000_0001);
      apb(1'b1, sps_pkg::ADDR_STATUS, 32'h0000_00FF);
      rdc(sps_pkg::ADDR_STATUS, 32'hFFFF_FFFF, 32'h0000_00C0);
      apb(1'b1, sps_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
      rdc(sps_pkg::ADDR_IRQ_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
      // spi: every polarity and edge pairing, masked interrupt first
      for (int c = 0; c < 4; c++)
      begin
         apb(1'b1, sps_pkg::ADDR_CONTROL, 32'h0000_0000);
         link.idle(c[1]);
         apb(1'b1, sps_pkg::ADDR_STATUS, {25'h0, c[0], 6'h0});
         apb(1'b1, sps_pkg::ADDR_IRQ_EN, {31'h0, c != 0});
         apb(1'b1, sps_pkg::ADDR_CONTROL, {26'h0, 1'b1, c[1], 4'h0});
         repeat (3)
         begin
            tx = 8'($urandom);
            rx = 8'($urandom);
            apb(1'b1, sps_pkg::ADDR_BUFFER, 32'(tx));
            link.spi_xfer(c[1], rx, got);
            repeat (4) @(posedge pclk);
            rdc(sps_pkg::ADDR_STATUS, 32'h0000_0041, {25'h0, c[0], 6'h1});
            rdc(sps_pkg::ADDR_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
            check(32'(irq), {31'h0, c != 0});
            rdc(sps_pkg::ADDR_BUFFER, 32'h0000_00FF, 32'(rx));
            rdc(sps_pkg::ADDR_STATUS, 32'h0000_0001, 32'h0000_0000);
            check(32'(got), 32'(tx));
            apb(1'b1, sps_pkg::ADDR_IRQ_CLR, 32'h0000_0007);
            repeat (2) @(posedge pclk);
            check(32'(irq), 32'h0000_0000);
         end
      end
      // i2c: address write, data, stop, then address read with transmit
      apb(1'b1, sps_pkg::ADDR_CONTROL, 32'h0000_0000);
      link.idle(1'b1);
      apb(1'b1, sps_pkg::ADDR_STATUS, 32'h0000_0000);
      own = 8'($urandom) & 8'h7F;
      apb(1'b1, sps_pkg::ADDR_OWN, 32'(own));
      apb(1'b1, sps_pkg::ADDR_CONTROL, 32'h0000_0021);
      link.i2c_cond(1'b0);
      rdc(sps_pkg::ADDR_STATUS, 32'h0000_0018, 32'h0000_0008);
      link.i2c_byte({own[6:0], 1'b0}, 1'b1, got, ack);
      check(32'(ack), 32'h0000_0001);
      rdc(sps_pkg::ADDR_STATUS, 32'h0000_0025, 32'h0000_0001);
      rdc(sps_pkg::ADDR_BUFFER, 32'h0000_00FF, {24'h0, own[6:0], 1'b0});
      tx = 8'($urandom);
      link.i2c_byte(tx, 1'b1, got, ack);
      rdc(sps_pkg::ADDR_STATUS, 32'h0000_0021, 32'h0000_0021);
      rdc(sps_pkg::ADDR_BUFFER, 32'h0000_00FF, 32'(tx));
      link.i2c_cond(1'b1);
      rdc(sps_pkg::ADDR_STATUS, 32'h0000_0019, 32'h0000_0010);
      link.i2c_cond(1'b0);
      link.i2c_byte({own[6:0], 1'b1}, 1'b1, got, ack);
      rdc(sps_pkg::ADDR_STATUS, 32'h0000_0024, 32'h0000_0004);
      rdc(sps_pkg::ADDR_BUFFER, 32'h0000_00FF, {24'h0, own[6:0], 1'b1});
      tx = 8'($urandom);
      apb(1'b1, sps_pkg::ADDR_BUFFER, 32'(tx));
      rdc(sps_pkg::ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
      link.i2c_byte(8'hFF, 1'b1, got, ack);
      check(32'(got), 32'(tx));
      rdc(sps_pkg::ADDR_STATUS, 32'h0000_0001, 32'h0000_0000);
      link.i2c_cond(1'b1);
      link.i2c_cond(1'b0);
      link.i2c_byte({own[6:0] ^ 7'h01, 1'b0}, 1'b1, got, ack);
      check(32'(ack), 32'h0000_0000);
      link.i2c_cond(1'b1);
      end_sim;
   end
endmodule
